/* File: logic/address_translation_unit.sv */
// Two-level virtual to physical address translation for fetch and data
`timescale 1ns/100ps
`include "xlate_defs.svh"

module address_translation_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration
  input wire logic fixed_page_64k,
  // Fetch unit requests and answers
  input wire logic fetch_req_valid,
  input wire xlate_pkg::hart_t fetch_req_hart,
  input wire xlate_pkg::vaddr_t fetch_req_vaddr,
  output logic fetch_req_ready,
  output logic fetch_resp_valid,
  output logic fetch_resp_fault,
  output xlate_pkg::vaddr_t fetch_resp_paddr,
  output xlate_pkg::attr_t fetch_resp_attr,
  // Load/store unit requests and answers
  input wire logic ls_req_valid,
  input wire xlate_pkg::hart_t ls_req_hart,
  input wire xlate_pkg::vaddr_t ls_req_vaddr,
  output logic ls_req_ready,
  output logic ls_resp_valid,
  output logic ls_resp_fault,
  output xlate_pkg::vaddr_t ls_resp_paddr,
  output xlate_pkg::attr_t ls_resp_attr,
  // Second-level entry fill from the table walker
  input wire logic fill_valid,
  input wire logic fill_fixed,
  input wire xlate_pkg::hart_t fill_hart,
  input wire logic [`VAR_IDX_W-1:0] fill_index,
  input wire xlate_pkg::vaddr_t fill_vaddr,
  input wire xlate_pkg::page_size_t fill_size,
  input wire xlate_pkg::ppn_t fill_ppn_even,
  input wire xlate_pkg::ppn_t fill_ppn_odd,
  input wire xlate_pkg::attr_t fill_attr_even,
  input wire xlate_pkg::attr_t fill_attr_odd
);
  import xlate_pkg::*;

  typedef struct packed {
    micro_entry_t [`NUM_REQ-1:0][`MICRO_DEPTH-1:0] micro;
    logic [`NUM_REQ-1:0][`MICRO_IDX_W-1:0] repl;
    pair_entry_t [`NUM_HARTS-1:0][`VAR_DEPTH-1:0] vbuf;
    logic [`NUM_REQ-1:0] ready;
    logic [`NUM_REQ-1:0] pend;
    hart_t [`NUM_REQ-1:0] pend_hart;
    vaddr_t [`NUM_REQ-1:0] pend_va;
    logic [`NUM_REQ-1:0] resp_valid;
    logic [`NUM_REQ-1:0] resp_fault;
    vaddr_t [`NUM_REQ-1:0] resp_paddr;
    attr_t [`NUM_REQ-1:0] resp_attr;
    walk_state_t st;
    logic sel;
    logic vhit;
    logic vbig;
    vaddr_t vpaddr;
    attr_t vattr;
  } state_t;

  state_t cur;
  state_t next_cur;
  fixed_array_if arr ();

  // ========================================================================
  // Request side views
  logic [`NUM_REQ-1:0] req_valid;
  hart_t [`NUM_REQ-1:0] req_hart;
  vaddr_t [`NUM_REQ-1:0] req_va;
  logic [`NUM_REQ-1:0][`MICRO_DEPTH-1:0] micro_match;
  logic [`NUM_REQ-1:0][`MICRO_DEPTH-1:0] micro_live;
  logic [`NUM_REQ-1:0] micro_hit;
  vaddr_t [`NUM_REQ-1:0] micro_pa;
  attr_t [`NUM_REQ-1:0] micro_attr;
  logic walk_sel;
  hart_t walk_hart;
  vaddr_t walk_va;
  logic [`VAR_DEPTH-1:0] var_match;
  page_size_t fixed_size;

  assign req_valid = {ls_req_valid, fetch_req_valid};
  assign req_hart = {ls_req_hart, fetch_req_hart};
  assign req_va = {ls_req_vaddr, fetch_req_vaddr};
  assign fixed_size = fixed_page_64k ? `PG_64K : `PG_4K;

  // Fetch has priority for the shared second-level lookup
  assign walk_sel = !cur.pend[`REQ_FETCH];
  assign walk_hart = cur.pend_hart[walk_sel];
  assign walk_va = cur.pend_va[walk_sel];

  // ========================================================================
  // Micro compare, every entry against the request, hart-tagged
  for (genvar r = 0; r < `NUM_REQ; r++) begin : g_req
    for (genvar e = 0; e < `MICRO_DEPTH; e++) begin : g_ent
      micro_entry_t me;
      assign me = cur.micro[r][e];
      assign micro_live[r][e] = me.valid;
      assign micro_match[r][e] = me.valid && me.hart == req_hart[r] &&
        (me.big ? me.vpn[`PPN_W-1:4] == req_va[r][`VA_W-1:16]
                : me.vpn == req_va[r][`VA_W-1:`PAGE_OFS_W]);
    end
  end

  // Variable-page compare against the walking hart's own copy only
  for (genvar v = 0; v < `VAR_DEPTH; v++) begin : g_var
    assign var_match[v] = pair_hit(cur.vbuf[walk_hart][v], walk_hart,
                                   walk_va);
  end

  // Micro hit data, 64 KB entries keep 16 offset bits
  always_comb begin
    for (int r = 0; r < `NUM_REQ; r++) begin
      micro_hit[r] = |micro_match[r];
      micro_pa[r] = '0;
      micro_attr[r] = '0;
      for (int e = 0; e < `MICRO_DEPTH; e++) begin
        if (micro_match[r][e]) begin
          micro_pa[r] = cur.micro[r][e].big ?
            {cur.micro[r][e].ppn[`PPN_W-1:4], req_va[r][15:0]} :
            {cur.micro[r][e].ppn, req_va[r][`PAGE_OFS_W-1:0]};
          micro_attr[r] = cur.micro[r][e].attr;
        end
      end
    end
  end

  // ========================================================================
  // Fixed-page array: read set of walking address, write from fill port
  always_comb begin
    arr.rd_en = cur.st == S_IDLE && |cur.pend;
    arr.rd_set = fixed_page_64k ?
      walk_va[`SET_LSB_64K +: `FIX_SET_W] :
      walk_va[`SET_LSB_4K +: `FIX_SET_W];
    arr.wr_en = fill_valid && fill_fixed;
    arr.wr_set = fixed_page_64k ?
      fill_vaddr[`SET_LSB_64K +: `FIX_SET_W] :
      fill_vaddr[`SET_LSB_4K +: `FIX_SET_W];
    arr.wr_way = fill_index[`FIX_WAY_W-1:0];
    arr.wr_data = '{valid: 1'b1, hart: fill_hart, size: fixed_size,
                    vpn: fill_vaddr[`VA_W-1:`PAGE_OFS_W],
                    ppn_even: fill_ppn_even, ppn_odd: fill_ppn_odd,
                    attr_even: fill_attr_even,
                    attr_odd: fill_attr_odd};
  end

  fixed_page_array u_fixed (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port(arr.store)
  );

  // ========================================================================
  // Request taking, second-level walk, refill and fill
  always_comb begin
    pair_entry_t fe;
    logic fhit;
    vaddr_t fpa;
    attr_t fattr;
    vaddr_t pa;
    micro_entry_t ne;
    fe = '0;
    fhit = 1'b0;
    fpa = '0;
    fattr = '0;
    pa = '0;
    ne = '0;
    next_cur = cur;
    next_cur.resp_valid = '0;
    // Take requests; micro hits answer in the next cycle
    for (int r = 0; r < `NUM_REQ; r++) begin
      if (cur.ready[r] && req_valid[r]) begin
        next_cur.pend_va[r] = req_va[r];
        next_cur.pend_hart[r] = req_hart[r];
        if (micro_hit[r]) begin
          next_cur.resp_valid[r] = 1'b1;
          next_cur.resp_fault[r] = 1'b0;
          next_cur.resp_paddr[r] = micro_pa[r];
          next_cur.resp_attr[r] = micro_attr[r];
        end else begin
          next_cur.pend[r] = 1'b1;
          next_cur.ready[r] = 1'b0;
        end
      end
    end
    unique case (cur.st)
      S_IDLE: begin
        if (|cur.pend) begin
          next_cur.st = S_CHECK;
          next_cur.sel = walk_sel;
          next_cur.vhit = |var_match;
          next_cur.vbig = 1'b0;
          next_cur.vpaddr = '0;
          next_cur.vattr = '0;
          for (int v = 0; v < `VAR_DEPTH; v++) begin
            if (var_match[v]) begin
              next_cur.vbig = cur.vbuf[walk_hart][v].size != `PG_4K;
              next_cur.vpaddr = pair_paddr(cur.vbuf[walk_hart][v],
                                           walk_va);
              next_cur.vattr = pair_attr(cur.vbuf[walk_hart][v], walk_va);
            end
          end
        end
      end
      S_CHECK: begin
        // Fixed ways are compared at the configured size
        for (int w = 0; w < `FIX_WAYS; w++) begin
          fe = arr.rd_data[w];
          fe.size = fixed_size;
          if (pair_hit(fe, cur.pend_hart[cur.sel], cur.pend_va[cur.sel])) begin
            fhit = 1'b1;
            fpa = pair_paddr(fe, cur.pend_va[cur.sel]);
            fattr = pair_attr(fe, cur.pend_va[cur.sel]);
          end
        end
        pa = cur.vhit ? cur.vpaddr : fpa;
        next_cur.resp_valid[cur.sel] = 1'b1;
        next_cur.resp_fault[cur.sel] = !(cur.vhit || fhit);
        next_cur.resp_paddr[cur.sel] = pa;
        next_cur.resp_attr[cur.sel] = cur.vhit ? cur.vattr : fattr;
        next_cur.pend[cur.sel] = 1'b0;
        next_cur.ready[cur.sel] = 1'b1;
        next_cur.st = S_IDLE;
        // Copy the result into the micro buffer that missed
        if (cur.vhit || fhit) begin
          ne.valid = 1'b1;
          ne.hart = cur.pend_hart[cur.sel];
          ne.big = cur.vhit ? cur.vbig : fixed_page_64k;
          ne.vpn = cur.pend_va[cur.sel][`VA_W-1:`PAGE_OFS_W];
          ne.ppn = pa[`VA_W-1:`PAGE_OFS_W];
          ne.attr = next_cur.resp_attr[cur.sel];
          next_cur.micro[cur.sel][cur.repl[cur.sel]] = ne;
          next_cur.repl[cur.sel] = cur.repl[cur.sel] + `MICRO_IDX_W'h1;
        end
      end
    endcase
    // A new second-level entry may shadow micro copies, so drop them all
    if (fill_valid) begin
      for (int r = 0; r < `NUM_REQ; r++) begin
        for (int e = 0; e < `MICRO_DEPTH; e++) begin
          next_cur.micro[r][e].valid = 1'b0;
        end
      end
      if (!fill_fixed) begin
        next_cur.vbuf[fill_hart][fill_index] = '{valid: 1'b1,
          hart: fill_hart, size: fill_size,
          vpn: fill_vaddr[`VA_W-1:`PAGE_OFS_W],
          ppn_even: fill_ppn_even, ppn_odd: fill_ppn_odd,
          attr_even: fill_attr_even, attr_odd: fill_attr_odd};
      end
    end
  end

  // State register; requesters may issue right after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.ready <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  // ========================================================================
  // Outputs, all from the state register
  assign fetch_req_ready = cur.ready[`REQ_FETCH];
  assign fetch_resp_valid = cur.resp_valid[`REQ_FETCH];
  assign fetch_resp_fault = cur.resp_fault[`REQ_FETCH];
  assign fetch_resp_paddr = cur.resp_paddr[`REQ_FETCH];
  assign fetch_resp_attr = cur.resp_attr[`REQ_FETCH];
  assign ls_req_ready = cur.ready[`REQ_LS];
  assign ls_resp_valid = cur.resp_valid[`REQ_LS];
  assign ls_resp_fault = cur.resp_fault[`REQ_LS];
  assign ls_resp_paddr = cur.resp_paddr[`REQ_LS];
  assign ls_resp_attr = cur.resp_attr[`REQ_LS];

  // ========================================================================
  // Checks
  a_fetch_hit_answer:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    fetch_req_valid && fetch_req_ready && micro_hit[`REQ_FETCH]
    |=> fetch_resp_valid && !fetch_resp_fault)
  else $error("fetch micro hit not answered next cycle");

  a_data_hit_answer:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    ls_req_valid && ls_req_ready && micro_hit[`REQ_LS]
    |=> ls_resp_valid && ls_resp_paddr[11:0] == $past(ls_req_vaddr[11:0]))
  else $error("data micro hit answer wrong");

  a_miss_lookup_start:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    fetch_req_valid && fetch_req_ready && !micro_hit[`REQ_FETCH]
    |-> ##[1:2] arr.rd_en)
  else $error("second-level lookup did not start after miss");

  a_miss_answer_bound:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    ls_req_valid && ls_req_ready && !micro_hit[`REQ_LS]
    |=> !ls_req_ready ##[2:4] ls_resp_valid)
  else $error("data miss not answered in time");

  a_refill_slot:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    fetch_resp_valid && !fetch_resp_fault && $past(cur.st == S_CHECK)
    && !$past(cur.sel) && !$past(fill_valid)
    |-> cur.micro[`REQ_FETCH][$past(cur.repl[`REQ_FETCH])].vpn
        == cur.pend_va[`REQ_FETCH][`VA_W-1:`PAGE_OFS_W])
  else $error("missed page not copied into fetch micro buffer");

  a_page_offset:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    fetch_resp_valid && !fetch_resp_fault
    |-> fetch_resp_paddr[11:0] == cur.pend_va[`REQ_FETCH][11:0])
  else $error("page offset not carried into physical address");

  a_fill_flush:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    fill_valid |=> micro_live == '0)
  else $error("micro entries survive a second-level fill");

  a_walk_one_at_time:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    cur.st == S_CHECK |=> cur.st == S_IDLE && $countones(cur.resp_valid
      & ~$past(cur.ready & req_valid & micro_hit)) == 1)
  else $error("second-level walk did not answer exactly once");

endmodule // address_translation_unit

/* File: logic/fixed_array_if.sv */
// Port bundle between the walker and the fixed-page entry array
`timescale 1ns/100ps
`include "xlate_defs.svh"

interface fixed_array_if;
  import xlate_pkg::*;
  logic rd_en;
  logic [`FIX_SET_W-1:0] rd_set;
  pair_entry_t [`FIX_WAYS-1:0] rd_data;
  logic wr_en;
  logic [`FIX_SET_W-1:0] wr_set;
  logic [`FIX_WAY_W-1:0] wr_way;
  pair_entry_t wr_data;

  modport walker (
    output rd_en, rd_set, wr_en, wr_set, wr_way, wr_data,
    input rd_data
  );
  modport store (
    input rd_en, rd_set, wr_en, wr_set, wr_way, wr_data,
    output rd_data
  );
endinterface

/* File: logic/fixed_page_array.sv */
// Set-associative entry store of the fixed-page buffer, registered read
`timescale 1ns/100ps
`include "xlate_defs.svh"

module fixed_page_array (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Walker side
  fixed_array_if.store port
);
  import xlate_pkg::*;

  typedef struct packed {
    pair_entry_t [`FIX_SETS-1:0][`FIX_WAYS-1:0] arr;
    pair_entry_t [`FIX_WAYS-1:0] rd_data;
  } array_state_t;

  array_state_t cur;
  array_state_t next_cur;

  // ========================================================================
  // Read returns all ways of a set one cycle later; write is one way
  always_comb begin
    next_cur = cur;
    if (port.rd_en) begin
      next_cur.rd_data = cur.arr[port.rd_set];
    end
    if (port.wr_en) begin
      next_cur.arr[port.wr_set][port.wr_way] = port.wr_data;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign port.rd_data = cur.rd_data;

  a_read_latency:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    port.rd_en && !port.wr_en |=> port.rd_data == $past(cur.arr[port.rd_set]))
  else $error("fixed array read data not from addressed set");

endmodule // fixed_page_array

/* File: logic/xlate_defs.svh */
// Widths, depths, page size codes and index positions of the translator
`ifndef XLATE_DEFS_SVH
`define XLATE_DEFS_SVH

// ==========================================================================
// Address and field widths
`define VA_W 48
`define PPN_W 36
`define PAGE_OFS_W 12
`define ATTR_W 8
`define NUM_HARTS 2
`define HART_W 1

// ==========================================================================
// Requesters
`define NUM_REQ 2
`define REQ_FETCH 0
`define REQ_LS 1

// ==========================================================================
// Buffer geometry
`define MICRO_DEPTH 8
`define MICRO_IDX_W 3
`define VAR_DEPTH 32
`define VAR_IDX_W 5
`define FIX_SETS 128
`define FIX_SET_W 7
`define FIX_WAYS 4
`define FIX_WAY_W 2
// Set index starts just above the even/odd page select bit
`define SET_LSB_4K 13
`define SET_LSB_64K 17

// ==========================================================================
// Page size codes and their shifts
`define PG_4K 3'h0
`define PG_64K 3'h1
`define PG_2M 3'h2
`define PG_1G 3'h3
`define PG_512G 3'h4
`define SH_4K 6'h0c
`define SH_64K 6'h10
`define SH_2M 6'h15
`define SH_1G 6'h1e
`define SH_512G 6'h27

`endif

/* File: logic/xlate_pkg.sv */
// Types and page arithmetic shared by the translator modules
`include "xlate_defs.svh"

package xlate_pkg;

  // ========================================================================
  // Basic types
  typedef logic [`VA_W-1:0] vaddr_t;
  typedef logic [`PPN_W-1:0] ppn_t;
  typedef logic [`ATTR_W-1:0] attr_t;
  typedef logic [`HART_W-1:0] hart_t;
  typedef logic [2:0] page_size_t;

  // Micro entry: one 4 KB or 64 KB page, tagged with its hart
  typedef struct packed {
    logic valid;
    hart_t hart;
    logic big;
    ppn_t vpn;
    ppn_t ppn;
    attr_t attr;
  } micro_entry_t;

  // Dual entry: even/odd page pair under one tag
  typedef struct packed {
    logic valid;
    hart_t hart;
    page_size_t size;
    ppn_t vpn;
    ppn_t ppn_even;
    ppn_t ppn_odd;
    attr_t attr_even;
    attr_t attr_odd;
  } pair_entry_t;

  typedef enum logic {S_IDLE, S_CHECK} walk_state_t;

  // ========================================================================
  // Mask of the bits above the page offset
  function automatic vaddr_t page_mask(page_size_t sz);
    logic [5:0] sh;
    vaddr_t one;
    one = `VA_W'h1;
    unique case (sz)
      `PG_4K: sh = `SH_4K;
      `PG_64K: sh = `SH_64K;
      `PG_2M: sh = `SH_2M;
      `PG_1G: sh = `SH_1G;
      `PG_512G: sh = `SH_512G;
      default: sh = `SH_4K;
    endcase
    page_mask = ~((one << sh) - one);
  endfunction

  // Tag match over the pair; only the owning hart may hit
  function automatic logic pair_hit(pair_entry_t e, hart_t h, vaddr_t va);
    vaddr_t m;
    m = vaddr_t'(page_mask(e.size) << 1);
    pair_hit = e.valid && (e.hart == h) &&
               (((va ^ {e.vpn, `PAGE_OFS_W'h0}) & m) == '0);
  endfunction

  // Odd page of the pair is picked by the bit just above the offset
  function automatic logic pair_odd(pair_entry_t e, vaddr_t va);
    vaddr_t m;
    m = page_mask(e.size);
    pair_odd = |(va & m & ~vaddr_t'(m << 1));
  endfunction

  function automatic vaddr_t pair_paddr(pair_entry_t e, vaddr_t va);
    vaddr_t m;
    ppn_t p;
    m = page_mask(e.size);
    p = pair_odd(e, va) ? e.ppn_odd : e.ppn_even;
    pair_paddr = ({p, `PAGE_OFS_W'h0} & m) | (va & ~m);
  endfunction

  function automatic attr_t pair_attr(pair_entry_t e, vaddr_t va);
    pair_attr = pair_odd(e, va) ? e.attr_odd : e.attr_even;
  endfunction

endpackage

/* File: tb/requester_model.sv */
// Requester model standing in for the fetch unit or the load/store unit
`timescale 1ns/100ps

module requester_model (
  // Clock
  input wire logic clk_sys,
  // Request lines
  output logic req_valid,
  output xlate_pkg::hart_t req_hart,
  output xlate_pkg::vaddr_t req_vaddr,
  // Answer lines
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_fault,
  input wire xlate_pkg::vaddr_t resp_paddr,
  input wire xlate_pkg::attr_t resp_attr
);
  import xlate_pkg::*;

  // ==========================================================================
  // Request lines idle at time zero
  initial begin
    req_valid = 1'h0;
    req_hart = 1'h0;
    req_vaddr = 48'h0;
  end

  // One translation: idle gap cycles, hold until taken, count to the answer;
  // the address is scrambled once taken so a stale value never looks valid
  task automatic issue(input hart_t h, input vaddr_t va, input int gap,
      output logic f, output vaddr_t pa, output attr_t at, output int lat);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge clk_sys);
    req_valid <= 1'h1;
    req_hart <= h;
    req_vaddr <= va;
    @(posedge clk_sys);
    while (req_ready !== 1'h1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    req_valid <= 1'h0;
    req_vaddr <= ~va;
    // Answer stands one cycle after its edge, so look just past each edge;
    // the cycle in which the request was taken counts as the first
    lat = 1;
    #1;
    while (resp_valid !== 1'h1 && lat < 20) begin
      @(posedge clk_sys);
      #1;
      lat++;
    end
    f = resp_fault;
    pa = resp_paddr;
    at = resp_attr;
  endtask
endmodule // requester_model

/* File: tb/two_level_address_translation_test.sv */
// Self-checking bench of the two-level address translator
`timescale 1ns/100ps
`include "xlate_defs.svh"

module two_level_address_translation_test;
  import xlate_pkg::*;

  typedef struct {
    logic side;
    hart_t hart;
    vaddr_t va;
    logic fault;
    vaddr_t pa;
    attr_t at;
    int lo;
    int hi;
  } row_t;

  // ==========================================================================
  // Signals
  logic clk_sys, rst_n = 1'h0, fixed_page_64k = 1'h0;
  logic fill_valid = 1'h0, fill_fixed = 1'h0;
  hart_t fill_hart = 1'h0;
  logic [`VAR_IDX_W-1:0] fill_index = 5'h0;
  vaddr_t fill_vaddr = 48'h0;
  page_size_t fill_size = 3'h0;
  ppn_t fill_ppn_even = 36'h0, fill_ppn_odd = 36'h0;
  attr_t fill_attr_even = 8'h0, fill_attr_odd = 8'h0;
  logic fetch_req_valid, fetch_req_ready, fetch_resp_valid, fetch_resp_fault;
  logic ls_req_valid, ls_req_ready, ls_resp_valid, ls_resp_fault;
  hart_t fetch_req_hart, ls_req_hart;
  vaddr_t fetch_req_vaddr, ls_req_vaddr, fetch_resp_paddr, ls_resp_paddr;
  attr_t fetch_resp_attr, ls_resp_attr;
  int n_fail = 0, cmp_count = 0;

  // Side, hart, address, fault, physical address, attribute, latency range
  row_t rows [16] = '{
    '{1'h0, 1'h0, 48'h000000402abc, 1'h0, 48'h0000aaa01abc, 8'h11, 3, 3},
    '{1'h0, 1'h0, 48'h000000402abc, 1'h0, 48'h0000aaa01abc, 8'h11, 1, 1},
    '{1'h0, 1'h0, 48'h000000403def, 1'h0, 48'h0000aaa02def, 8'h12, 3, 3},
    '{1'h0, 1'h1, 48'h000000402abc, 1'h1, 48'h0, 8'h0, 3, 3},
    '{1'h1, 1'h0, 48'h000000402abc, 1'h0, 48'h0000aaa01abc, 8'h11, 3, 3},
    '{1'h1, 1'h0, 48'h000000402abc, 1'h0, 48'h0000aaa01abc, 8'h11, 1, 1},
    '{1'h1, 1'h1, 48'h000080612345, 1'h0, 48'h0000c0212345, 8'h22, 3, 3},
    '{1'h1, 1'h1, 48'h000080612345, 1'h0, 48'h0000c0212345, 8'h22, 1, 1},
    '{1'h0, 1'h1, 48'h000080510000, 1'h0, 48'h0000c0110000, 8'h21, 3, 3},
    '{1'h0, 1'h0, 48'h000000604321, 1'h0, 48'h000050004321, 8'h41, 3, 3},
    '{1'h0, 1'h0, 48'h004012345678, 1'h0, 48'h000412345678, 8'h51, 3, 3},
    '{1'h1, 1'h0, 48'h018000001234, 1'h0, 48'h880000001234, 8'h32, 3, 3},
    '{1'h0, 1'h0, 48'h000001235010, 1'h0, 48'h000077002010, 8'h62, 3, 3},
    '{1'h1, 1'h1, 48'h000001235010, 1'h1, 48'h0, 8'h0, 3, 3},
    '{1'h0, 1'h0, 48'h0000dead0000, 1'h1, 48'h0, 8'h0, 3, 3},
    '{1'h1, 1'h0, 48'h000080612345, 1'h1, 48'h0, 8'h0, 3, 3}
  };

  // ==========================================================================
  // Design and the two requesters
  address_translation_unit dut (.clk_sys, .rst_n, .fixed_page_64k,
    .fetch_req_valid, .fetch_req_hart, .fetch_req_vaddr, .fetch_req_ready,
    .fetch_resp_valid, .fetch_resp_fault, .fetch_resp_paddr, .fetch_resp_attr,
    .ls_req_valid, .ls_req_hart, .ls_req_vaddr, .ls_req_ready, .ls_resp_valid,
    .ls_resp_fault, .ls_resp_paddr, .ls_resp_attr, .fill_valid, .fill_fixed,
    .fill_hart, .fill_index, .fill_vaddr, .fill_size, .fill_ppn_even,
    .fill_ppn_odd, .fill_attr_even, .fill_attr_odd);

  requester_model fetch_req (.clk_sys, .req_valid(fetch_req_valid),
    .req_hart(fetch_req_hart), .req_vaddr(fetch_req_vaddr),
    .req_ready(fetch_req_ready), .resp_valid(fetch_resp_valid),
    .resp_fault(fetch_resp_fault), .resp_paddr(fetch_resp_paddr),
    .resp_attr(fetch_resp_attr));

  requester_model ls_req (.clk_sys, .req_valid(ls_req_valid),
    .req_hart(ls_req_hart), .req_vaddr(ls_req_vaddr),
    .req_ready(ls_req_ready), .resp_valid(ls_resp_valid),
    .resp_fault(ls_resp_fault), .resp_paddr(ls_resp_paddr),
    .resp_attr(ls_resp_attr));

  // Clock of 5 ns
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input vaddr_t exp, input vaddr_t got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset with a chosen fixed page size; outputs checked while held
  task automatic do_reset(input logic big);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    fixed_page_64k <= big;
    repeat (2) @(posedge clk_sys);
    check("fetch ready", 48'h1, vaddr_t'(fetch_req_ready));
    check("ls ready", 48'h1, vaddr_t'(ls_req_ready));
    check("resp valid", 48'h0, vaddr_t'({fetch_resp_valid, ls_resp_valid}));
    rst_n <= 1'h1;
  endtask

  // Load one even/odd pair into a second-level buffer
  task automatic fill(input logic fx, input hart_t h, input logic [4:0] ix,
      input vaddr_t va, input page_size_t sz, input ppn_t pe, input ppn_t po,
      input attr_t ae, input attr_t ao);
    @(posedge clk_sys);
    fill_valid <= 1'h1;
    fill_fixed <= fx;
    fill_hart <= h;
    fill_index <= ix;
    fill_vaddr <= va;
    fill_size <= sz;
    fill_ppn_even <= pe;
    fill_ppn_odd <= po;
    fill_attr_even <= ae;
    fill_attr_odd <= ao;
    @(posedge clk_sys);
    fill_valid <= 1'h0;
    fill_vaddr <= ~va;
  endtask

  // One request through the matching requester, answer compared
  task automatic run_row(input row_t r, input int gap);
    logic f;
    vaddr_t pa;
    attr_t at;
    int lat;
    if (r.side)
      ls_req.issue(r.hart, r.va, gap, f, pa, at, lat);
    else
      fetch_req.issue(r.hart, r.va, gap, f, pa, at, lat);
    check("fault", vaddr_t'(r.fault), vaddr_t'(f));
    if (!r.fault) begin
      check("paddr", r.pa, pa);
      check("attr", vaddr_t'(r.at), vaddr_t'(at));
    end
    check("latency", 48'h1, vaddr_t'(lat >= r.lo && lat <= r.hi));
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    do_reset(1'h0);
    fill(1'h0, 1'h0, 5'h00, 48'h000000402000, 3'h0, 36'h0000aaa01,
      36'h0000aaa02, 8'h11, 8'h12);
    fill(1'h0, 1'h1, 5'h03, 48'h000080400000, 3'h2, 36'h0000c0000,
      36'h0000c0200, 8'h21, 8'h22);
    fill(1'h0, 1'h0, 5'h1f, 48'h010000000000, 3'h4, 36'h800000000,
      36'h880000000, 8'h31, 8'h32);
    fill(1'h0, 1'h0, 5'h02, 48'h000000600000, 3'h1, 36'h000050000,
      36'h000051000, 8'h41, 8'h42);
    fill(1'h0, 1'h0, 5'h01, 48'h004000000000, 3'h3, 36'h000400000,
      36'h000480000, 8'h51, 8'h52);
    fill(1'h1, 1'h0, 5'h03, 48'h000001234000, 3'h0, 36'h000077001,
      36'h000077002, 8'h61, 8'h62);
    foreach (rows[i])
      run_row(rows[i], i % 3);
    // Refilled page hits, then any fill flushes the micro buffers
    run_row(rows[1], 0);
    fill(1'h1, 1'h0, 5'h03, 48'h000001234000, 3'h0, 36'h000077001,
      36'h000077002, 8'h61, 8'h62);
    run_row(rows[0], 0);
    // Both sides miss together: fetch first, load/store waits its turn
    fork
      run_row(rows[10], 0);
      run_row('{1'h1, 1'h1, 48'h000080612345, 1'h0, 48'h0000c0212345,
        8'h22, 4, 5}, 0);
    join
    // Second reset empties everything; fixed buffer now in 64 KB pages
    do_reset(1'h1);
    run_row(rows[14], 0);
    run_row('{1'h0, 1'h0, 48'h000000402abc, 1'h1, 48'h0, 8'h0, 3, 3}, 0);
    fill(1'h1, 1'h1, 5'h00, 48'h00000abc0000, 3'h0, 36'h000088000,
      36'h000089000, 8'h71, 8'h72);
    run_row('{1'h1, 1'h1, 48'h00000abd1234, 1'h0, 48'h000089001234,
      8'h72, 3, 3}, 0);
    complete_run();
  end

  // Watchdog well beyond the expected run of about 120 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule // two_level_address_translation_test
